// file: rtl/quad_dac_pkg.sv
package quad_dac_pkg;

  // ----------------------------------------
  // frame layout
  // ----------------------------------------
  localparam int FRAME_BITS = 16;
  localparam int DATA_BITS = 12;
  localparam int NUM_CHAN = 4;
  localparam logic [4:0] FRAME_LAST = 5'h10;
  localparam logic [4:0] COUNT_ZERO = 5'h00;
  localparam logic [4:0] COUNT_ONE = 5'h01;
  localparam logic [15:0] SHIFT_RESET = 16'h0000;
  localparam logic [11:0] CODE_ZERO = 12'h000;

  // ----------------------------------------
  // decoded command codes
  // ----------------------------------------
  localparam logic [1:0] LOAD_INPUT = 2'h0;
  localparam logic [1:0] LOAD_CONV = 2'h1;
  localparam logic [1:0] LOAD_BOTH = 2'h2;
  localparam logic [1:0] LOAD_ALL = 2'h3;
  localparam logic [1:0] SEL_POWER_DOWN = 2'h3;

  // output termination while powered down
  typedef enum logic [1:0] {
    TERM_ACTIVE = 2'h0,
    TERM_HIZ = 2'h1,
    TERM_1K = 2'h2,
    TERM_100K = 2'h3
  } term_t;

  // frame receiver states, gray along idle -> shift -> done
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SHIFT = 2'b01,
    ST_DONE = 2'b11
  } frame_state_t;

  // one received frame as fields
  typedef struct packed {
    logic load_ctrl_hi;
    logic load_ctrl_lo;
    logic chan_sel_hi;
    logic chan_sel_lo;
    logic all_channels_flag;
    logic pd_chan_hi;
    logic pd_chan_lo;
    logic pd_term_hi;
    logic pd_term_lo;
    logic [6:0] spare;
  } frame_t;

  // serial link pins
  typedef struct packed {
    logic sync_n;
    logic sclk;
    logic sdin;
  } link_t;

endpackage

// file: rtl/quad_dac_serial_command_unit.sv
`timescale 1ns/1ps
// How it works
// - a 16-bit shift register gathers one command frame per transfer
// - four control bits come first, then twelve data bits
// - bits arrive most significant first, bit 15 down to bit 0
// - load bits pick input register, converter register or both
// - select bits pick channel A, B, C or D
// - both load bits high means the command hits all channels, except a power down with the flag clear
// - data is plain unsigned binary, zero to full scale minus a step
// - converter code D gives reference_level times D over 4096
// - bits are taken only while frame-sync is low
// - data sampled on each serial clock falling edge for 16 pulses
// - edges and data after the sixteenth falling edge are ignored
// - after a full frame, a new one needs frame-sync high then low
// - a finished frame updates the selected registers automatically
// - frame-sync rising early discards the partial frame
// - all control bits set is power down; flag bit applies to all channels
// - with the flag clear, two bits pick the powered-down channel
// - two bits choose termination: hi-z, 1k, 100k, hi-z
// - reset clears every register but the pin synchronisers, which load idle levels; outputs at zero scale
// - single-channel load codes: input only, copy to converter, both
// - load code 11: select picks all-input, all-update, all-both, power down
module quad_dac_serial_command_unit (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // serial link pins
  input wire logic sync_n,
  input wire logic sclk,
  input wire logic sdin,
  // converter and input codes, output terminations and frame strobe, channel A at index 0
  output logic [11:0] conv_code [4],
  output logic [11:0] input_code [4],
  output quad_dac_pkg::term_t chan_term [4],
  output logic frame_done
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  quad_dac_pkg::link_t pin_meta;
  quad_dac_pkg::link_t pin_sync;
  quad_dac_pkg::link_t pin_prev;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pin_meta <= 3'b110;
      pin_sync <= 3'b110;
      pin_prev <= 3'b110;
    end else begin
      pin_meta <= '{sync_n: sync_n, sclk: sclk, sdin: sdin};
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  logic sclk_fall;
  logic sync_fall;
  logic sync_rise;
  assign sclk_fall = pin_prev.sclk && !pin_sync.sclk;
  assign sync_fall = pin_prev.sync_n && !pin_sync.sync_n;
  assign sync_rise = !pin_prev.sync_n && pin_sync.sync_n;

  // ----------------------------------------
  // frame receiver
  // ----------------------------------------
  quad_dac_pkg::frame_state_t state;
  logic [15:0] shift;
  logic [4:0] bit_count;
  logic commit;

  assign commit = (state == quad_dac_pkg::ST_SHIFT) && sclk_fall && !pin_sync.sync_n
    && (bit_count == quad_dac_pkg::FRAME_LAST - quad_dac_pkg::COUNT_ONE);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state <= quad_dac_pkg::ST_IDLE;
      shift <= quad_dac_pkg::SHIFT_RESET;
      bit_count <= quad_dac_pkg::COUNT_ZERO;
    end else begin
      case (state)
        quad_dac_pkg::ST_IDLE: begin
          if (sync_fall) begin
            state <= quad_dac_pkg::ST_SHIFT;
            bit_count <= quad_dac_pkg::COUNT_ZERO;
          end
        end
        quad_dac_pkg::ST_SHIFT: begin
          if (pin_sync.sync_n) begin
            state <= quad_dac_pkg::ST_IDLE;
          end else if (sclk_fall) begin
            shift <= {shift[14:0], pin_sync.sdin};
            bit_count <= bit_count + quad_dac_pkg::COUNT_ONE;
            if (commit) begin
              state <= quad_dac_pkg::ST_DONE;
            end
          end
        end
        quad_dac_pkg::ST_DONE: begin
          if (sync_rise || pin_sync.sync_n) begin
            state <= quad_dac_pkg::ST_IDLE;
          end
        end
        default: state <= quad_dac_pkg::ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // command decode
  // ----------------------------------------
  quad_dac_pkg::frame_t cmd;
  logic [1:0] load_code;
  logic [1:0] sel_code;
  logic [11:0] new_data;
  assign cmd = quad_dac_pkg::frame_t'({shift[14:0], pin_sync.sdin});
  assign load_code = {cmd.load_ctrl_hi, cmd.load_ctrl_lo};
  assign sel_code = {cmd.chan_sel_hi, cmd.chan_sel_lo};
  assign new_data = {cmd.all_channels_flag, cmd.pd_chan_hi, cmd.pd_chan_lo,
    cmd.pd_term_hi, cmd.pd_term_lo, cmd.spare};

  logic power_down_cmd;
  assign power_down_cmd = (load_code == quad_dac_pkg::LOAD_ALL)
    && (sel_code == quad_dac_pkg::SEL_POWER_DOWN);

  quad_dac_pkg::term_t pd_term;
  always_comb begin
    case ({cmd.pd_term_hi, cmd.pd_term_lo})
      2'h1: pd_term = quad_dac_pkg::TERM_1K;
      2'h2: pd_term = quad_dac_pkg::TERM_100K;
      default: pd_term = quad_dac_pkg::TERM_HIZ;
    endcase
  end

  // ----------------------------------------
  // channel registers
  // ----------------------------------------
  for (genvar ch = 0; ch < quad_dac_pkg::NUM_CHAN; ch++) begin : g_chan
    logic hit;
    logic pd_hit;
    logic wr_input;
    logic wr_conv;
    logic copy_conv;
    always_comb begin
      hit = (load_code == quad_dac_pkg::LOAD_ALL) || (sel_code == 2'(ch));
      pd_hit = cmd.all_channels_flag || ({cmd.pd_chan_hi, cmd.pd_chan_lo} == 2'(ch));
      wr_input = 1'b0;
      wr_conv = 1'b0;
      copy_conv = 1'b0;
      if (!power_down_cmd && hit) begin
        if (load_code == quad_dac_pkg::LOAD_ALL) begin
          wr_input = (sel_code == quad_dac_pkg::LOAD_INPUT)
            || (sel_code == quad_dac_pkg::LOAD_BOTH);
          copy_conv = (sel_code == quad_dac_pkg::LOAD_CONV);
          wr_conv = (sel_code == quad_dac_pkg::LOAD_BOTH);
        end else begin
          wr_input = (load_code == quad_dac_pkg::LOAD_INPUT)
            || (load_code == quad_dac_pkg::LOAD_BOTH);
          copy_conv = (load_code == quad_dac_pkg::LOAD_CONV);
          wr_conv = (load_code == quad_dac_pkg::LOAD_BOTH);
        end
      end
    end

    always_ff @(posedge clk_sys) begin
      if (rst) begin
        input_code[ch] <= quad_dac_pkg::CODE_ZERO;
        conv_code[ch] <= quad_dac_pkg::CODE_ZERO;
        chan_term[ch] <= quad_dac_pkg::TERM_ACTIVE;
      end else if (commit) begin
        if (wr_input) begin
          input_code[ch] <= new_data;
        end
        if (wr_conv) begin
          conv_code[ch] <= new_data;
          chan_term[ch] <= quad_dac_pkg::TERM_ACTIVE;
        end else if (copy_conv) begin
          conv_code[ch] <= input_code[ch];
          chan_term[ch] <= quad_dac_pkg::TERM_ACTIVE;
        end
        if (power_down_cmd && pd_hit) begin
          chan_term[ch] <= pd_term;
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      frame_done <= 1'b0;
    end else begin
      frame_done <= commit;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // every check samples on clk_sys and rests while rst is high

  // receiver sequencing
  count_bound_a: assert property (bit_count <= quad_dac_pkg::FRAME_LAST)
    else $error("bit count beyond frame length");
  shift_step_a: assert property ((state == quad_dac_pkg::ST_SHIFT) && sclk_fall
    && !pin_sync.sync_n |=> bit_count == $past(bit_count) + quad_dac_pkg::COUNT_ONE)
    else $error("falling edge did not advance the bit count");
  shift_in_a: assert property ((state == quad_dac_pkg::ST_SHIFT) && sclk_fall
    && !pin_sync.sync_n |=> shift[0] == $past(pin_sync.sdin)
    && shift[15:1] == $past(shift[14:0]))
    else $error("serial bit not shifted in at the bottom");
  idle_quiet_a: assert property ((state == quad_dac_pkg::ST_IDLE) && pin_sync.sync_n
    |=> state == quad_dac_pkg::ST_IDLE && $stable(shift))
    else $error("receiver moved while frame-sync high");
  abort_idle_a: assert property ((state == quad_dac_pkg::ST_SHIFT) && pin_sync.sync_n
    |=> state == quad_dac_pkg::ST_IDLE)
    else $error("early frame-sync rise did not abort");
  abort_keep_a: assert property ((state == quad_dac_pkg::ST_SHIFT) && pin_sync.sync_n
    |=> $stable(input_code[0]) && $stable(conv_code[0]))
    else $error("aborted frame changed a register");
  done_hold_a: assert property ((state == quad_dac_pkg::ST_DONE) && !pin_sync.sync_n
    |=> state == quad_dac_pkg::ST_DONE)
    else $error("new frame started without frame-sync toggling");
  done_quiet_a: assert property (state == quad_dac_pkg::ST_DONE |=> !frame_done)
    else $error("extra edges produced a commit");
  done_freeze_a: assert property (state == quad_dac_pkg::ST_DONE
    |=> $stable(shift) && !commit)
    else $error("shift register moved after the sixteenth edge");
  start_zero_a: assert property (sync_fall && state == quad_dac_pkg::ST_IDLE
    |=> bit_count == quad_dac_pkg::COUNT_ZERO)
    else $error("counter not cleared at frame start");
  commit_pulse_a: assert property (commit |=> frame_done ##1 !frame_done)
    else $error("frame_done not a single pulse");
  done_cause_a: assert property (frame_done |-> $past(commit))
    else $error("frame_done without a completed frame");

  // register updates
  both_write_a: assert property (commit && !power_down_cmd
    && load_code == quad_dac_pkg::LOAD_BOTH && sel_code == 2'h0
    |=> conv_code[0] == $past(new_data) && input_code[0] == $past(new_data))
    else $error("load both did not write channel A");
  copy_conv_a: assert property (commit && !power_down_cmd
    && load_code == quad_dac_pkg::LOAD_CONV && sel_code == 2'h1
    |=> conv_code[1] == $past(input_code[1]) && $stable(input_code[1]))
    else $error("copy to converter missed channel B");
  store_only_a: assert property (commit && load_code == quad_dac_pkg::LOAD_INPUT
    && sel_code == 2'h3 |=> input_code[3] == $past(new_data) && $stable(conv_code[3]))
    else $error("store command touched converter register D");
  chan_only_a: assert property (commit && load_code == quad_dac_pkg::LOAD_BOTH
    && sel_code == 2'h1 |=> conv_code[1] == $past(new_data)
    && $stable(conv_code[0]) && $stable(conv_code[2]) && $stable(conv_code[3]))
    else $error("single channel write touched another channel");
  term_revive_a: assert property (commit && load_code == quad_dac_pkg::LOAD_BOTH
    && sel_code == 2'h0 |=> chan_term[0] == quad_dac_pkg::TERM_ACTIVE)
    else $error("converter write left channel A powered down");
  all_input_a: assert property (commit && load_code == quad_dac_pkg::LOAD_ALL
    && sel_code == quad_dac_pkg::LOAD_INPUT
    |=> input_code[0] == $past(new_data) && input_code[3] == $past(new_data)
    && $stable(conv_code[2]))
    else $error("all-channel store missed a channel");
  all_update_a: assert property (commit && load_code == quad_dac_pkg::LOAD_ALL
    && sel_code == quad_dac_pkg::LOAD_CONV
    |=> conv_code[2] == $past(input_code[2]) && conv_code[3] == $past(input_code[3]))
    else $error("all-channel update missed a channel");
  all_both_a: assert property (commit && load_code == quad_dac_pkg::LOAD_ALL
    && sel_code == quad_dac_pkg::LOAD_BOTH
    |=> conv_code[0] == $past(new_data) && conv_code[1] == $past(new_data)
    && conv_code[2] == $past(new_data) && conv_code[3] == $past(new_data))
    else $error("all-channel write missed a channel");
  reset_zero_a: assert property ($fell(rst)
    |-> conv_code[0] == quad_dac_pkg::CODE_ZERO && input_code[3] == quad_dac_pkg::CODE_ZERO
    && !frame_done && chan_term[2] == quad_dac_pkg::TERM_ACTIVE)
    else $error("register not at zero scale after reset");

  // power down
  pd_codes_a: assert property (commit && power_down_cmd
    |=> $stable(input_code[2]) && $stable(conv_code[2]))
    else $error("power down changed a code");
  pd_all_a: assert property (commit && power_down_cmd && cmd.all_channels_flag
    && pd_term == quad_dac_pkg::TERM_1K |=> chan_term[3] == quad_dac_pkg::TERM_1K)
    else $error("power down all missed channel D");
  pd_single_a: assert property (commit && power_down_cmd && !cmd.all_channels_flag
    && cmd.pd_chan_hi && !cmd.pd_chan_lo
    |=> chan_term[2] == $past(pd_term) && $stable(chan_term[0]))
    else $error("single power down hit the wrong channel");
  pd_chan_d_a: assert property (commit && power_down_cmd && !cmd.all_channels_flag
    && cmd.pd_chan_hi && cmd.pd_chan_lo && !cmd.pd_term_hi && cmd.pd_term_lo
    |=> chan_term[3] == quad_dac_pkg::TERM_1K && $stable(chan_term[2]))
    else $error("power down channel D 1k not applied");
  pd_hiz_a: assert property (commit && power_down_cmd && cmd.all_channels_flag
    && cmd.pd_term_hi && cmd.pd_term_lo |=> chan_term[1] == quad_dac_pkg::TERM_HIZ)
    else $error("termination code 11 not high impedance");

  // ----------------------------------------
  // cover points
  // ----------------------------------------
  frame_c: cover property (commit);
  abort_c: cover property ((state == quad_dac_pkg::ST_SHIFT) && pin_sync.sync_n);
  pd_c: cover property (commit && power_down_cmd);
  copy_c: cover property (commit && load_code == quad_dac_pkg::LOAD_CONV);
  extra_c: cover property ((state == quad_dac_pkg::ST_DONE) && sclk_fall && !pin_sync.sync_n);

endmodule

// file: verification/host_link_model.sv
`timescale 1ns/1ps
module host_link_model (
  // clock
  input wire logic clk_sys,
  // link pins
  output quad_dac_pkg::link_t pins
);
  initial pins = 3'b110;
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // each phase is 4 clk_sys cycles, well below 50 MHz
  task automatic pulse();
    tick(4);
    pins.sclk = 1'b0;
    tick(4);
    pins.sclk = 1'b1;
  endtask
  // bit 15 first, then down to bit 0; short nbits aborts
  task automatic frame(input logic [15:0] w, input int nbits, input int extra);
    pins.sync_n = 1'b0;
    for (int i = 0; i < nbits + extra; i++) begin
      pins.sdin = (i < nbits) ? w[15 - i] : ~pins.sdin;
      pulse();
    end
    // frame-sync held low past the last falling edge
    tick(4);
    pins.sync_n = 1'b1;
    pins.sdin = ~pins.sdin;
    for (int i = 0; i < extra; i++) pulse();
    tick(6);
  endtask
endmodule

// file: verification/quad_dac_serial_command_unit_tb.sv
`timescale 1ns/1ps
module quad_dac_serial_command_unit_tb;
  logic clk_sys;
  logic rst;
  quad_dac_pkg::link_t pins;
  logic [11:0] conv_code [4];
  logic [11:0] input_code [4];
  quad_dac_pkg::term_t chan_term [4];
  logic frame_done;
  logic [11:0] exp_conv [4];
  logic [11:0] exp_in [4];
  quad_dac_pkg::term_t exp_term [4];
  logic [11:0] n_done;
  logic [11:0] exp_done;
  int n_fail;
  int n_compared;

  quad_dac_serial_command_unit quad_dac_serial_command_unit_inst (
    .clk_sys(clk_sys), .rst(rst), .sync_n(pins.sync_n), .sclk(pins.sclk),
    .sdin(pins.sdin), .conv_code(conv_code), .input_code(input_code),
    .chan_term(chan_term), .frame_done(frame_done));
  host_link_model host_link_model_inst (.clk_sys(clk_sys), .pins(pins));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (rst) n_done <= 12'h000;
    else if (frame_done === 1'b1) n_done <= n_done + 12'h001;
  end

  // ------------------------------
  // expected state
  // ------------------------------
  function automatic void clear_exp();
    for (int c = 0; c < 4; c++) begin
      exp_in[c] = 12'h000;
      exp_conv[c] = 12'h000;
      exp_term[c] = quad_dac_pkg::TERM_ACTIVE;
    end
    exp_done = 12'h000;
  endfunction
  function automatic void apply(input logic [15:0] f);
    logic [1:0] lc;
    quad_dac_pkg::term_t t;
    t = (f[8:7] == 2'h1) ? quad_dac_pkg::TERM_1K :
        (f[8:7] == 2'h2) ? quad_dac_pkg::TERM_100K : quad_dac_pkg::TERM_HIZ;
    lc = (f[15:14] == 2'h3) ? f[13:12] : f[15:14];
    for (int c = 0; c < 4; c++) begin
      if (f[15:12] == 4'hf) begin
        if (f[11] || f[10:9] == c[1:0]) exp_term[c] = t;
      end else if (f[15:14] == 2'h3 || f[13:12] == c[1:0]) begin
        if (lc != 2'h1) exp_in[c] = f[11:0];
        if (lc != 2'h0) begin
          exp_conv[c] = exp_in[c];
          exp_term[c] = quad_dac_pkg::TERM_ACTIVE;
        end
      end
    end
    exp_done = exp_done + 12'h001;
  endfunction

  task automatic cmp_val(input logic [11:0] got, input logic [11:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_term(input quad_dac_pkg::term_t got, input quad_dac_pkg::term_t exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic check_all();
    for (int c = 0; c < 4; c++) begin
      cmp_val(input_code[c], exp_in[c]);
      cmp_val(conv_code[c], exp_conv[c]);
      cmp_term(chan_term[c], exp_term[c]);
    end
    cmp_val(n_done, exp_done);
  endtask
  task automatic send(input logic [15:0] f);
    host_link_model_inst.frame(f, 16, 0);
    apply(f);
    check_all();
  endtask
  task automatic test_done();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ------------------------------
  // tests
  // ------------------------------
  initial begin
    rst = 1'b1;
    n_fail = 0;
    n_compared = 0;
    clear_exp();
    void'($urandom(32'hb57b));
    repeat (6) @(posedge clk_sys);
    #1 rst = 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    check_all();
    $display("test reset done");
    for (int k = 0; k < 16; k++) send({k[3:0], 12'($urandom)});
    send(16'h2fff);
    send(16'h2000);
    $display("test codes done");
    for (int k = 0; k < 32; k++) begin
      send({4'he, 12'($urandom)});
      send({4'hf, k[4:0], 7'($urandom)});
    end
    $display("test power down done");
    host_link_model_inst.frame(16'h2abc, 10, 0);
    check_all();
    send(16'h6123);
    host_link_model_inst.frame(16'h2abc, 16, 16);
    apply(16'h2abc);
    check_all();
    $display("test framing done");
    for (int k = 0; k < 40; k++) send(16'($urandom));
    $display("test random done");
    rst = 1'b1;
    clear_exp();
    repeat (2) @(posedge clk_sys);
    #1 rst = 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    check_all();
    send(16'hb5a5);
    $display("test second reset done");
    test_done();
  end
  initial begin
    #400us;
    n_fail++;
    test_done();
  end
endmodule
